/* File: testbench/fscfr_host_model.sv */
// host controller model issuing serial register commands
`timescale 1ns/100ps

module fscfr_host_model (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic [3:0] io_drv,
  input wire logic [3:0] io_rcv,
  input wire logic [3:0] io_oe
);

  logic [3:0] seen_oe;

  // --------------------------------------------------------------
  // idle link: clock parked low, data lines held at 5h
  // --------------------------------------------------------------
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    io_drv = 4'h5;
    seen_oe = 4'h0;
  end

  // --------------------------------------------------------------
  // one frame: command, optional data byte, optional read byte
  // --------------------------------------------------------------
  task automatic frame(input logic [7:0] cmd, input int w, input int nwr,
                       input int nrd, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [15:0] sh;
    logic [3:0] bits;
    int n;
    sh = {cmd, wd};
    n = (8 + 8 * nwr) / w;
    rd = 8'h00;
    spi_cs_n = 1'b0;
    // msb first, w bits per link clock
    for (int i = 0; i < n; i++) begin
      io_drv = sh[15:12] >> (4 - w);
      sh = sh << w;
      #3 spi_clk = 1'b1;
      #3 spi_clk = 1'b0;
    end
    io_drv = ~io_drv;
    // read byte sampled on rising edges, released lines keep toggling
    for (int i = 0; i < nrd * 8 / w; i++) begin
      #3 spi_clk = 1'b1;
      bits = (w == 1) ? {3'h0, io_rcv[1]} :
             (w == 2) ? {2'h0, io_rcv[1:0]} : io_rcv;
      rd = (rd << w) | {4'h0, bits};
      seen_oe = io_oe;
      #3 spi_clk = 1'b0;
      io_drv = ~io_drv;
    end
    #3 spi_cs_n = 1'b1;
    io_drv = ~io_drv;
    // gap between frames
    #700;
  endtask : frame

endmodule : fscfr_host_model

/* File: testbench/fscfr_regs_tb_top.sv */
// self-checking bench of the segment, protocol and flag registers
`timescale 1ns/100ps

module fscfr_regs_tb_top
  import fscfr_pkg::*;
;

  logic sys_clk, sys_rst, spi_clk, spi_cs_n;
  logic [3:0] spi_io_in, spi_io_out, spi_io_oe;
  logic nv_seg_default, addr4_mode, write_in_progress;
  logic erase_suspended, program_suspended, erase_fail, program_fail;
  logic accel_supply_bad, protect_fail, op_start, read_next;
  logic [31:0] op_addr, array_addr;
  logic [1:0] segment;
  fscfr_proto_t protocol;
  logic hold_reset_en, accel_program_en;
  logic [2:0] drive_code;
  logic [7:0] flags, rd;
  int num_errors, tests_run, cycles, cur_w;

  // --------------------------------------------------------------
  // design and host model
  // --------------------------------------------------------------
  fscfr_regs fscfr_regs_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_io_in(spi_io_in),
    .spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe),
    .nv_seg_default(nv_seg_default), .addr4_mode(addr4_mode),
    .write_in_progress(write_in_progress),
    .erase_suspended(erase_suspended),
    .program_suspended(program_suspended), .erase_fail(erase_fail),
    .program_fail(program_fail), .accel_supply_bad(accel_supply_bad),
    .protect_fail(protect_fail), .op_start(op_start), .op_addr(op_addr),
    .read_next(read_next), .array_addr(array_addr), .segment(segment),
    .protocol(protocol), .hold_reset_en(hold_reset_en),
    .accel_program_en(accel_program_en), .drive_code(drive_code),
    .flags(flags));

  fscfr_host_model fscfr_host_model_i (.spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .io_drv(spi_io_in), .io_rcv(spi_io_out),
    .io_oe(spi_io_oe));

  // --------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // frame in the current protocol, then time for the commit to land
  task automatic cmd(input logic [7:0] c, input int nwr, input logic [7:0] wd);
    fscfr_host_model_i.frame(c, cur_w, nwr, 1 - nwr, wd, rd);
    step(12);
  endtask : cmd

  // address request, answer visible on the following edge
  task automatic op(input logic [31:0] a, input logic nxt);
    op_addr = a;
    op_start = !nxt;
    read_next = nxt;
    step(1);
    op_start = 1'b0;
    read_next = 1'b0;
    step(1);
  endtask : op

  task automatic results;
    $display("tests run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset_values;
    check(flags, 8'h80);
    check({30'h0, protocol}, {30'h0, FSCFR_EXT});
    check({29'h0, hold_reset_en, accel_program_en, drive_code},
          {29'h0, 5'b1_0111});
    check(segment, 2'h3);
    cmd(8'hC8, 0, 8'h00);
    check(rd, 8'h03);
    cmd(8'h65, 0, 8'h00);
    check(rd, 8'hDF);
    cmd(8'h70, 0, 8'h00);
    check(rd, 8'h80);
    $display("done: reset values");
  endtask : t_reset_values

  task automatic t_segment;
    for (int s = 0; s < 4; s++) begin
      cmd(8'hC5, 1, 8'hFC | 8'(s));
      cmd(8'hC8, 0, 8'h00);
      check(rd, 8'(s));
      op(32'hA512_3456, 1'b0);
      check(array_addr, {6'h0, 2'(s), 24'h12_3456});
    end
    $display("done: segment select");
  endtask : t_segment

  task automatic t_wrap;
    cmd(8'hC5, 1, 8'h02);
    op(32'h00FF_FFFF, 1'b0);
    check(array_addr, 32'h02FF_FFFF);
    op(32'h0000_0000, 1'b1);
    check(array_addr, 32'h0300_0000);
    check(segment, 2'h2);
    cmd(8'hC5, 1, 8'h03);
    op(32'h00FF_FFFF, 1'b0);
    op(32'h0000_0000, 1'b1);
    check(array_addr, 32'h0200_0000);
    cmd(8'hC8, 0, 8'h00);
    check(rd, 8'h03);
    $display("done: read wrap");
  endtask : t_wrap

  task automatic t_addr4;
    addr4_mode = 1'b1;
    step(2);
    check(flags, 8'h81);
    op(32'hFEDC_BA98, 1'b0);
    check(array_addr, 32'hFEDC_BA98);
    addr4_mode = 1'b0;
    step(2);
    check(flags, 8'h80);
    $display("done: four byte mode");
  endtask : t_addr4

  task automatic t_protocol;
    logic [7:0] vals [4];
    logic [7:0] v;
    fscfr_proto_t p;
    vals = '{8'h5A, 8'h27, 8'hB3, 8'hDF};
    for (int i = 0; i < 4; i++) begin
      v = vals[i];
      cmd(8'h61, 1, v);
      p = !v[7] ? FSCFR_QUAD : !v[6] ? FSCFR_DUAL : FSCFR_EXT;
      cur_w = (p == FSCFR_QUAD) ? 4 : (p == FSCFR_DUAL) ? 2 : 1;
      check({30'h0, protocol}, {30'h0, p});
      check({29'h0, hold_reset_en, accel_program_en, drive_code},
            {29'h0, v[4], !v[3], v[2:0]});
      cmd(8'h65, 0, 8'h00);
      check(rd, v & 8'hDF);
      check(fscfr_host_model_i.seen_oe,
            (cur_w == 4) ? 4'hF : (cur_w == 2) ? 4'h3 : 4'h2);
      cmd(8'h70, 0, 8'h00);
      check(rd, 8'h80);
    end
    $display("done: protocol config");
  endtask : t_protocol

  task automatic t_live_flags;
    write_in_progress = 1'b1;
    step(2);
    check(flags, 8'h00);
    cmd(8'h70, 0, 8'h00);
    check(rd, 8'h00);
    write_in_progress = 1'b0;
    erase_suspended = 1'b1;
    program_suspended = 1'b1;
    step(2);
    check(flags, 8'hC4);
    erase_suspended = 1'b0;
    program_suspended = 1'b0;
    step(2);
    check(flags, 8'h80);
    $display("done: live flags");
  endtask : t_live_flags

  task automatic t_error_flags;
    logic [7:0] bits [4];
    bits = '{8'h20, 8'h10, 8'h08, 8'h02};
    for (int i = 0; i < 4; i++) begin
      {erase_fail, program_fail, accel_supply_bad, protect_fail} =
        4'h8 >> i;
      step(1);
      {erase_fail, program_fail, accel_supply_bad, protect_fail} = 4'h0;
      step(3);
      check(flags, 8'h80 | bits[i]);
      cmd(8'h70, 0, 8'h00);
      check(rd, 8'h80 | bits[i]);
      check(flags, 8'h80 | bits[i]);
      // clear command carries no data byte
      fscfr_host_model_i.frame(8'h50, cur_w, 0, 0, 8'h00, rd);
      step(12);
      check(flags, 8'h80);
    end
    $display("done: error flags");
  endtask : t_error_flags

  task automatic t_reset_again;
    protect_fail = 1'b1;
    step(1);
    protect_fail = 1'b0;
    nv_seg_default = 1'b0;
    sys_rst = 1'b1;
    step(3);
    sys_rst = 1'b0;
    step(6);
    check(segment, 2'h0);
    check(flags, 8'h80);
    $display("done: second reset");
  endtask : t_reset_again

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    cur_w = 1;
    sys_rst = 1'b1;
    nv_seg_default = 1'b1;
    {addr4_mode, write_in_progress, erase_suspended} = 3'h0;
    {program_suspended, erase_fail, program_fail} = 3'h0;
    {accel_supply_bad, protect_fail, op_start, read_next} = 4'h0;
    op_addr = 32'h0000_0000;
    step(12);
    sys_rst = 1'b0;
    step(6);
    t_reset_values();
    t_segment();
    t_wrap();
    t_addr4();
    t_protocol();
    t_live_flags();
    t_error_flags();
    t_reset_again();
    results();
  end

endmodule : fscfr_regs_tb_top

/* File: verilog/fscfr_defs.svh */
// constants of the segment, protocol and flag register group
`ifndef FSCFR_DEFS_SVH
`define FSCFR_DEFS_SVH

// --------------------------------------------------------------
// serial command codes
// --------------------------------------------------------------
`define FSCFR_CMD_RD_FLAGS 8'h70
`define FSCFR_CMD_CLR_FLAGS 8'h50
`define FSCFR_CMD_RD_SEG 8'hC8
`define FSCFR_CMD_WR_SEG 8'hC5
`define FSCFR_CMD_RD_PIO 8'h65
`define FSCFR_CMD_WR_PIO 8'h61

// --------------------------------------------------------------
// protocol/io configuration fields
// --------------------------------------------------------------
`define FSCFR_PIO_RST 8'hDF
`define FSCFR_PIO_QUAD 7
`define FSCFR_PIO_DUAL 6
`define FSCFR_PIO_RSVD 5
`define FSCFR_PIO_HOLD 4
`define FSCFR_PIO_ACCEL 3

// --------------------------------------------------------------
// segment select and array address fields
// --------------------------------------------------------------
`define FSCFR_SEG_RST 2'h0
`define FSCFR_SEG_LO 24
`define FSCFR_DIE_BIT 25

// --------------------------------------------------------------
// operation flag bits
// --------------------------------------------------------------
`define FSCFR_FLG_RST 8'h80
`define FSCFR_FLG_READY 7
`define FSCFR_FLG_ESUSP 6
`define FSCFR_FLG_EERR 5
`define FSCFR_FLG_PERR 4
`define FSCFR_FLG_SUPPLY 3
`define FSCFR_FLG_PSUSP 2
`define FSCFR_FLG_PROT 1
`define FSCFR_FLG_ADDR4 0

`endif

/* File: verilog/fscfr_pkg.sv */
// types of the segment, protocol and flag register group
package fscfr_pkg;

  // io protocol in force on the serial link
  typedef enum logic [1:0] {
    FSCFR_EXT,
    FSCFR_DUAL,
    FSCFR_QUAD
  } fscfr_proto_t;

  // frame decoder state on the link clock
  typedef enum logic [1:0] {
    FSCFR_LS_CMD,
    FSCFR_LS_DIN,
    FSCFR_LS_DOUT,
    FSCFR_LS_SKIP
  } fscfr_lstate_t;

endpackage : fscfr_pkg

/* File: verilog/fscfr_regs.sv */
// segment select, protocol/io config and operation flag registers
`timescale 1ns/100ps
`include "fscfr_defs.svh"

//
// Contract
// - 3-byte mode takes top byte from segment
// - bits 1:0 pick 128Mb segment, rest zero
// - program/erase stay in selected segment
// - reads wrap within enclosing 256Mb die
// - read past segment leaves segment unchanged
// - segment starts from strap, host may rewrite
// - 4-byte mode ignores segment register
// - active low bits 7/6 pick quad/dual
// - new protocol applies after write completes
// - bit 4 enables hold/reset pin
// - bit 3 low enables accelerated programming
// - config readable and writable in all protocols
// - flag bit 7 low while busy
// - flag bit 7 is inverse of busy
// - bits 6/2 show erase/program suspend
// - bits 5/4 latch erase/program failure
// - bit 3 latches bad accelerator supply
// - bit 1 latches protection violation
// - bit 0 shows 4-byte addressing
// - error bits stay until clear command
// - status bits follow live, all volatile
// - 70h reads flags, 50h clears errors
// - C8h reads segment, C5h writes it
module fscfr_regs
  import fscfr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_in,
  output logic [3:0] spi_io_out,
  output logic [3:0] spi_io_oe,
  input wire logic nv_seg_default,
  input wire logic addr4_mode,
  input wire logic write_in_progress,
  input wire logic erase_suspended,
  input wire logic program_suspended,
  input wire logic erase_fail,
  input wire logic program_fail,
  input wire logic accel_supply_bad,
  input wire logic protect_fail,
  input wire logic op_start,
  input wire logic [31:0] op_addr,
  input wire logic read_next,
  output logic [31:0] array_addr,
  output logic [1:0] segment,
  output fscfr_proto_t protocol,
  output logic hold_reset_en,
  output logic accel_program_en,
  output logic [2:0] drive_code,
  output logic [7:0] flags
);

  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------

  // protocol from config byte, bits active low
  function automatic fscfr_proto_t proto_of(input logic [7:0] b);
    if (!b[`FSCFR_PIO_QUAD]) begin
      proto_of = FSCFR_QUAD;
    end else if (!b[`FSCFR_PIO_DUAL]) begin
      proto_of = FSCFR_DUAL;
    end else begin
      proto_of = FSCFR_EXT;
    end
  endfunction : proto_of

  // bits moved per link clock
  function automatic logic [3:0] wbits(input fscfr_proto_t p);
    unique case (p)
      FSCFR_QUAD: wbits = 4'h4;
      FSCFR_DUAL: wbits = 4'h2;
      FSCFR_EXT: wbits = 4'h1;
      default: wbits = 4'h1;
    endcase
  endfunction : wbits

  // shift fresh link bits into a byte
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic [3:0] io,
                                          input fscfr_proto_t p);
    unique case (p)
      FSCFR_QUAD: shift_in = {s[3:0], io[3:0]};
      FSCFR_DUAL: shift_in = {s[5:0], io[1:0]};
      FSCFR_EXT: shift_in = {s[6:0], io[0]};
      default: shift_in = {s[6:0], io[0]};
    endcase
  endfunction : shift_in

  // top bits of a byte placed on the output lines
  function automatic logic [3:0] top_bits(input logic [7:0] b,
                                          input fscfr_proto_t p);
    unique case (p)
      FSCFR_QUAD: top_bits = b[7:4];
      FSCFR_DUAL: top_bits = {2'h0, b[7:6]};
      FSCFR_EXT: top_bits = {2'h0, b[7], 1'b0};
      default: top_bits = {2'h0, b[7], 1'b0};
    endcase
  endfunction : top_bits

  // output lines driven in each protocol
  function automatic logic [3:0] oe_mask(input fscfr_proto_t p);
    unique case (p)
      FSCFR_QUAD: oe_mask = 4'hF;
      FSCFR_DUAL: oe_mask = 4'h3;
      FSCFR_EXT: oe_mask = 4'h2;
      default: oe_mask = 4'h2;
    endcase
  endfunction : oe_mask

  // array address from command address and segment
  function automatic logic [31:0] map_addr(input logic [31:0] a,
                                           input logic [1:0] seg,
                                           input logic four);
    if (four) begin
      map_addr = a;
    end else begin
      map_addr = {6'h0, seg, a[23:0]};
    end
  endfunction : map_addr

  // --------------------------------------------------------------
  // link clock domain: frame decode
  // --------------------------------------------------------------
  fscfr_lstate_t lst_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] lcmd_r;
  fscfr_proto_t lproto_r;
  logic lpend_r;
  logic [7:0] lbyte_r;
  logic evt_tog_r;
  logic [7:0] evt_cmd_r;
  logic [7:0] evt_data_r;
  logic [23:0] sn1_r;
  logic [23:0] sn2_r;
  logic [23:0] snap_r;
  logic [2:0] oc_r;
  logic [7:0] osh_r;
  logic [3:0] out_r;
  logic [3:0] oe_r;
  fscfr_proto_t proto_eff;
  logic [3:0] wb;
  logic [3:0] bsum;
  logic [7:0] nsh;
  logic first;
  logic cmd_done;
  logic din_done;
  logic [7:0] sel;
  logic [7:0] cur;

  // pending config write takes hold at the next frame
  assign proto_eff = lpend_r ? proto_of(lbyte_r) : lproto_r;
  assign wb = wbits(proto_eff);
  assign bsum = {1'b0, cnt_r} + wb;
  assign nsh = shift_in(sh_r, spi_io_in, proto_eff);
  assign first = (lst_r == FSCFR_LS_CMD) && (cnt_r == 3'h0);
  assign cmd_done = (lst_r == FSCFR_LS_CMD) && (bsum == 4'h8);
  assign din_done = (lst_r == FSCFR_LS_DIN) && (bsum == 4'h8);

  // frame state, cleared whenever chip select is high
  always_ff @(posedge spi_clk or posedge spi_cs_n or posedge sys_rst) begin
    if (sys_rst || spi_cs_n) begin
      lst_r <= FSCFR_LS_CMD;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      lcmd_r <= 8'h00;
    end else begin
      sh_r <= nsh;
      cnt_r <= bsum[2:0];
      if (cmd_done) begin
        lcmd_r <= nsh;
        unique case (nsh)
          `FSCFR_CMD_RD_FLAGS, `FSCFR_CMD_RD_SEG, `FSCFR_CMD_RD_PIO: begin
            lst_r <= FSCFR_LS_DOUT;
          end
          `FSCFR_CMD_WR_SEG, `FSCFR_CMD_WR_PIO: begin
            lst_r <= FSCFR_LS_DIN;
          end
          default: begin
            lst_r <= FSCFR_LS_SKIP;
          end
        endcase
      end else if (din_done) begin
        lst_r <= FSCFR_LS_SKIP; // extra bytes ignored
      end
    end
  end

  // link-side protocol shadow, survives between frames
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lproto_r <= FSCFR_EXT;
      lpend_r <= 1'b0;
      lbyte_r <= `FSCFR_PIO_RST;
    end else begin
      if (first) begin
        lproto_r <= proto_eff;
        lpend_r <= 1'b0;
      end
      if (din_done && lcmd_r == `FSCFR_CMD_WR_PIO) begin
        lpend_r <= 1'b1;
        lbyte_r <= nsh;
      end
    end
  end

  // write/clear events handed to the system clock by toggle
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_tog_r <= 1'b0;
      evt_cmd_r <= 8'h00;
      evt_data_r <= 8'h00;
    end else if (din_done) begin
      evt_tog_r <= ~evt_tog_r;
      evt_cmd_r <= lcmd_r;
      evt_data_r <= nsh;
    end else if (cmd_done && nsh == `FSCFR_CMD_CLR_FLAGS) begin
      evt_tog_r <= ~evt_tog_r;
      evt_cmd_r <= nsh;
      evt_data_r <= 8'h00;
    end
  end

  // register snapshot brought over by two flops
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sn1_r <= 24'h00_0000;
      sn2_r <= 24'h00_0000;
    end else begin
      sn1_r <= snap_r;
      sn2_r <= sn1_r;
    end
  end

  // byte chosen by the read command
  always_comb begin
    sel = sn2_r[7:0];
    if (lcmd_r == `FSCFR_CMD_RD_FLAGS) begin
      sel = sn2_r[23:16];
    end else if (lcmd_r == `FSCFR_CMD_RD_PIO) begin
      sel = sn2_r[15:8];
    end
    cur = (oc_r == 3'h0) ? sel : osh_r;
  end

  // read data shifted out on the falling edge, repeats forever
  always_ff @(negedge spi_clk or posedge spi_cs_n or posedge sys_rst) begin
    if (sys_rst || spi_cs_n) begin
      oc_r <= 3'h0;
      osh_r <= 8'h00;
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (lst_r == FSCFR_LS_DOUT) begin
      out_r <= top_bits(cur, lproto_r);
      osh_r <= cur << wbits(lproto_r);
      oc_r <= oc_r + 3'(wbits(lproto_r));
      oe_r <= oe_mask(lproto_r);
    end
  end

  assign spi_io_out = out_r;
  assign spi_io_oe = oe_r;

  // --------------------------------------------------------------
  // system clock domain: crossing in
  // --------------------------------------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic hs_pend_r;
  logic [7:0] hs_cmd_r;
  logic [7:0] hs_data_r;
  logic apply;
  logic clr_now;

  // chip select and event toggle synchronisers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      cs_s1_r <= spi_cs_n;
      cs_s2_r <= cs_s1_r;
      tog_s1_r <= evt_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  // command held until its frame ends
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_pend_r <= 1'b0;
      hs_cmd_r <= 8'h00;
      hs_data_r <= 8'h00;
    end else if (tog_s2_r != tog_s3_r) begin
      hs_pend_r <= 1'b1;
      hs_cmd_r <= evt_cmd_r;
      hs_data_r <= evt_data_r;
    end else if (apply) begin
      hs_pend_r <= 1'b0;
    end
  end

  assign apply = hs_pend_r && cs_s2_r;
  assign clr_now = apply && hs_cmd_r == `FSCFR_CMD_CLR_FLAGS;

  // --------------------------------------------------------------
  // system clock domain: registers
  // --------------------------------------------------------------
  logic init_r;
  logic [1:0] seg_r;
  logic [7:0] pio_r;
  logic [7:0] flags_r;
  logic [31:0] addr_r;

  // segment select: strap after reset, then host writes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_r <= 1'b0;
      seg_r <= `FSCFR_SEG_RST;
    end else if (!init_r) begin
      init_r <= 1'b1;
      seg_r <= {nv_seg_default, nv_seg_default};
    end else if (apply && hs_cmd_r == `FSCFR_CMD_WR_SEG) begin
      seg_r <= hs_data_r[1:0];
    end
  end

  // protocol/io config, reserved bit forced low
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pio_r <= `FSCFR_PIO_RST;
    end else if (apply && hs_cmd_r == `FSCFR_CMD_WR_PIO) begin
      pio_r <= hs_data_r & ~(8'h01 << `FSCFR_PIO_RSVD);
    end
  end

  // flags: live status bits, sticky error bits, set wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= `FSCFR_FLG_RST;
    end else begin
      flags_r[`FSCFR_FLG_READY] <= ~write_in_progress;
      flags_r[`FSCFR_FLG_ESUSP] <= erase_suspended;
      flags_r[`FSCFR_FLG_PSUSP] <= program_suspended;
      flags_r[`FSCFR_FLG_ADDR4] <= addr4_mode;
      flags_r[`FSCFR_FLG_EERR] <= erase_fail |
        (flags_r[`FSCFR_FLG_EERR] & ~clr_now);
      flags_r[`FSCFR_FLG_PERR] <= program_fail |
        (flags_r[`FSCFR_FLG_PERR] & ~clr_now);
      flags_r[`FSCFR_FLG_SUPPLY] <= accel_supply_bad |
        (flags_r[`FSCFR_FLG_SUPPLY] & ~clr_now);
      flags_r[`FSCFR_FLG_PROT] <= protect_fail |
        (flags_r[`FSCFR_FLG_PROT] & ~clr_now);
    end
  end

  // array address: mapped at start, die-bound increment on reads
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r <= 32'h0000_0000;
    end else if (op_start) begin
      addr_r <= map_addr(op_addr, seg_r, addr4_mode);
    end else if (read_next) begin
      addr_r <= {addr_r[31:`FSCFR_DIE_BIT],
                 addr_r[`FSCFR_DIE_BIT-1:0] + 25'h1};
    end
  end

  // snapshot for the link, frozen while a frame runs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_r <= {`FSCFR_FLG_RST, `FSCFR_PIO_RST, 8'h00};
    end else if (cs_s2_r) begin
      snap_r <= {flags_r, pio_r, 6'h00, seg_r};
    end
  end

  // outputs
  assign array_addr = addr_r;
  assign segment = seg_r;
  assign protocol = proto_of(pio_r);
  assign hold_reset_en = pio_r[`FSCFR_PIO_HOLD];
  assign accel_program_en = ~pio_r[`FSCFR_PIO_ACCEL];
  assign drive_code = pio_r[2:0];
  assign flags = flags_r;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property p_addr3;
    op_start && !addr4_mode |=> array_addr[25:24] == $past(seg_r) &&
      array_addr[23:0] == $past(op_addr[23:0]) && array_addr[31:26] == 6'h0;
  endproperty
  a_addr3: assert property (p_addr3)
    else $error("3-byte address not mapped to segment");

  property p_addr4;
    op_start && addr4_mode |=> array_addr == $past(op_addr);
  endproperty
  a_addr4: assert property (p_addr4)
    else $error("4-byte address altered");

  property p_die_wrap;
    !op_start && read_next |=> array_addr[31:25] == $past(array_addr[31:25]);
  endproperty
  a_die_wrap: assert property (p_die_wrap)
    else $error("read left its die");

  property p_seg_keep;
    read_next && !apply ##1 !apply |=> $stable(seg_r);
  endproperty
  a_seg_keep: assert property (p_seg_keep)
    else $error("segment changed by read");

  property p_ready;
    ##1 flags[7] == !$past(write_in_progress);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag not inverse of busy");

  property p_sticky;
    flags[5] && !clr_now |=> flags[5];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("erase error cleared without command");

  property p_err_set;
    program_fail |=> flags[4];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("program error not latched");

  property p_addr_mode;
    ##1 flags[0] == $past(addr4_mode);
  endproperty
  a_addr_mode: assert property (p_addr_mode)
    else $error("address mode flag wrong");

  property p_proto;
    (protocol == FSCFR_QUAD) == !pio_r[7] &&
      (protocol == FSCFR_DUAL) == (pio_r[7] && !pio_r[6]);
  endproperty
  a_proto: assert property (p_proto)
    else $error("protocol decode wrong");

  property p_seg_write;
    apply && hs_cmd_r == 8'hC5 && init_r |=> seg_r == $past(hs_data_r[1:0]);
  endproperty
  a_seg_write: assert property (p_seg_write)
    else $error("segment write lost");

endmodule : fscfr_regs
